// >>> hdl/sfs_pkg.sv
// Shared constants and types for the sample buffer and timing sync block.
package sfs_pkg;

   // Register offsets.
   localparam logic [7:0] STATUS1_ADDR        = 8'h00;
   localparam logic [7:0] WRITE_POINTER_ADDR  = 8'h08;
   localparam logic [7:0] READ_POINTER_ADDR   = 8'h09;
   localparam logic [7:0] COUNT_HIGH_ADDR     = 8'h0A;
   localparam logic [7:0] COUNT_LOW_ADDR      = 8'h0B;
   localparam logic [7:0] DATA_PORT_ADDR      = 8'h0C;
   localparam logic [7:0] THRESHOLD_ADDR      = 8'h0D;
   localparam logic [7:0] BUFFER_CONTROL_ADDR = 8'h0E;
   localparam logic [7:0] TIMING_SYNC_ADDR    = 8'h10;
   localparam logic [7:0] SYSTEM_SETUP_ADDR   = 8'h11;
   localparam logic [7:0] IRQ_ENABLE_ADDR     = 8'h80;

   // Field positions.
   localparam int STAT_AF_BIT       = 7;
   localparam int STAT_DRDY_BIT     = 5;
   localparam int EN_AF_BIT         = 7;
   localparam int EN_DRDY_BIT       = 5;
   localparam int CTRL_MARK_BIT     = 5;
   localparam int CTRL_FLUSH_BIT    = 4;
   localparam int CTRL_STAT_CLR_BIT = 3;
   localparam int CTRL_AF_TYPE_BIT  = 2;
   localparam int CTRL_ROLL_BIT     = 1;
   localparam int SYNC_RESET_BIT    = 7;
   localparam int ROLE_BIT          = 7;

   // Reset values, empty data-port read value and lost counter limit.
   localparam logic [7:0] PTR_RESET       = 8'h00;
   localparam logic [7:0] THRESHOLD_RESET = 8'h7F;
   localparam logic [7:0] DATA_PORT_EMPTY = 8'hFF;
   localparam logic       STAT_CLR_RESET  = 1'b1;
   localparam logic       ROLL_RESET      = 1'b1;
   localparam logic [6:0] LOST_MAX        = 7'h7F;

   // Buffer shape and tags; the marker code is arbitrary.
   localparam int          DEPTH            = 256;
   localparam int          BYTES_PER_SAMPLE = 3;
   localparam logic [23:0] MARKER_TAG       = 24'hFFFFFE;

   // Divider ratios and sync pulse timing.
   localparam int ADC_DIV_FAST      = 512;
   localparam int ADC_DIV_SLOW      = 1024;
   localparam int CLK_PERIOD_NS     = 20;
   localparam int SYNC_PULSE_NS     = 100;
   localparam int SYNC_PULSE_CYCLES = (SYNC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Trigger output drive codes.
   localparam logic [1:0] DRIVE_OPEN_DRAIN = 2'h0;
   localparam logic [1:0] DRIVE_PUSH_HIGH  = 2'h1;
   localparam logic [1:0] DRIVE_PUSH_LOW   = 2'h2;

   // Byte phase within a three-byte sample read.
   typedef enum logic [2:0] {
      BYTE_HI  = 3'b001,
      BYTE_MID = 3'b010,
      BYTE_LO  = 3'b100
   } sfs_byte_e;

   // One register access from the serial interface.
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } sfs_reg_req_s;

endpackage : sfs_pkg

// >>> hdl/sfs_sample_fifo_sync.sv
// Sample buffer with pointers, counters, flags, and the timing sync divider logic.
`timescale 1ns/100ps

// Notes on behaviour
// - Write pointer steps per push, wraps 0xFF.
// - Read pointer steps per sample read, wraps.
// - Read pointer writable only with PLL on.
// - Nine-bit unread count, split over two registers.
// - Seven-bit lost counter saturates at 0x7F.
// - Completed sample read clears lost counter.
// - Data drained by non-incrementing burst reads.
// - Three bytes per sample, then pointer advances.
// - Almost-full at 256 minus threshold entries.
// - Enabled almost-full drives interrupt; status clears.
// - Marker bit pushes tag, then self-clears.
// - Flush zeroes pointers, count, lost counter.
// - Status-clear option lets data reads clear flags.
// - Almost-full type selects reassertion policy.
// - Rollover overwrites oldest, both pointers step.
// - Stop mode drops samples, pointers hold.
// - Timing reset clears divider in controller role unless measuring.
// - Controller role emits sync pulse on trigger.
// - Target role resets divider on trigger edge.
// - Role selects trigger direction and edge/drive.
// - New sample sets data-ready; status read clears.
// - Divider ratio 512 or 1024 by select.
module sfs_sample_fifo_sync #(
   parameter int DATA_W = 24
) (
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   input  wire logic                 ce,
   input  wire sfs_pkg::sfs_reg_req_s reg_req,
   output logic [7:0]                reg_rdata,
   input  wire logic                 sample_valid,
   input  wire logic [DATA_W-1:0]    sample_data,
   input  wire logic                 pll_enable,
   input  wire logic                 adc_div_select,
   input  wire logic                 bandgap_enable,
   input  wire logic                 inphase_channel_enable,
   input  wire logic                 quadrature_channel_enable,
   input  wire logic                 trigger_input_edge,
   input  wire logic [1:0]           trigger_output_drive,
   input  wire logic                 sync_trigger_pin_in,
   output logic                      sync_trigger_pin_out,
   output logic                      sync_trigger_pin_oe_n,
   output logic                      irq,
   output logic                      adc_clk
);

   // Buffer storage and pointer state.
   logic [DATA_W-1:0]  mem [sfs_pkg::DEPTH];
   logic [7:0]         write_pointer;
   logic [7:0]         read_pointer;
   logic [8:0]         count;
   logic [6:0]         lost_sample_counter;
   sfs_pkg::sfs_byte_e byte_phase;
   logic               mark_pending;

   // Configuration registers.
   logic [7:0] threshold;
   logic       status_clear_on_data_read;
   logic       af_type;
   logic       rollover_on_full;
   logic       sync_role;
   logic       af_enable;
   logic       drdy_enable;

   // Flags, divider and trigger state.
   logic       a_full;
   logic       data_ready;
   logic       af_armed;
   logic [9:0] div_cnt;
   logic [2:0] pulse_cnt;
   logic       sync_trigger_pin_meta;
   logic       sync_trigger_pin_sync;
   logic       sync_trigger_pin_prev;

   // Access decode.
   wire logic wr_stb      = reg_req.wr;
   wire logic rd_stb      = reg_req.rd;
   wire logic data_rd     = rd_stb && (reg_req.addr == sfs_pkg::DATA_PORT_ADDR);
   wire logic stat_rd     = rd_stb && (reg_req.addr == sfs_pkg::STATUS1_ADDR);
   wire logic ctrl_wr     = wr_stb && (reg_req.addr == sfs_pkg::BUFFER_CONTROL_ADDR);
   wire logic flush       = ctrl_wr && reg_req.wdata[sfs_pkg::CTRL_FLUSH_BIT];
   wire logic rd_ptr_wr   = wr_stb && (reg_req.addr == sfs_pkg::READ_POINTER_ADDR)
                            && pll_enable;
   wire logic tsr_wr      = wr_stb && (reg_req.addr == sfs_pkg::TIMING_SYNC_ADDR)
                            && reg_req.wdata[sfs_pkg::SYNC_RESET_BIT];

   // Buffer movement: a sample wins the slot over a pending marker.
   wire logic              have_data = (count != 9'h000);
   wire logic              full      = (count == 9'(sfs_pkg::DEPTH));
   wire logic              pop       = data_rd && have_data
                                       && (byte_phase == sfs_pkg::BYTE_LO);
   wire logic              push_req  = sample_valid || mark_pending;
   wire logic [DATA_W-1:0] push_word = sample_valid ? sample_data
                                       : DATA_W'(sfs_pkg::MARKER_TAG);
   wire logic              room      = !full || pop;
   wire logic              accept    = push_req && (room || rollover_on_full);
   wire logic              overwrite = push_req && !room && rollover_on_full;
   wire logic              lost      = push_req && !room;

   // Next pointer and count values; flush beats everything else.
   logic [7:0] next_write_pointer;
   logic [7:0] next_read_pointer;
   logic [8:0] next_count;
   logic [6:0] next_lost;
   always_comb
   begin
      next_write_pointer = accept ? write_pointer + 8'h01 : write_pointer;
      next_read_pointer  = read_pointer;
      next_count         = count;
      next_lost          = lost_sample_counter;
      if (pop || overwrite)
      begin
         next_read_pointer = read_pointer + 8'h01;
      end
      if (accept && !overwrite && !pop)
      begin
         next_count = count + 9'h001;
      end
      else if (pop && !accept)
      begin
         next_count = count - 9'h001;
      end
      if (pop)
      begin
         next_lost = 7'h00;
      end
      else if (lost && (lost_sample_counter != sfs_pkg::LOST_MAX))
      begin
         next_lost = lost_sample_counter + 7'h01;
      end
      if (rd_ptr_wr)
      begin
         // Re-reading rebuilds the count from the pointer gap, a same-cycle push included.
         next_read_pointer = reg_req.wdata;
         next_count        = {1'b0, next_write_pointer - reg_req.wdata};
      end
      if (flush)
      begin
         next_write_pointer = sfs_pkg::PTR_RESET;
         next_read_pointer  = sfs_pkg::PTR_RESET;
         next_count         = 9'h000;
         next_lost          = 7'h00;
      end
   end

   // Pointer, count and lost counter registers.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         write_pointer       <= sfs_pkg::PTR_RESET;
         read_pointer        <= sfs_pkg::PTR_RESET;
         count               <= 9'h000;
         lost_sample_counter <= 7'h00;
      end
      else if (ce)
      begin
         write_pointer       <= next_write_pointer;
         read_pointer        <= next_read_pointer;
         count               <= next_count;
         lost_sample_counter <= next_lost;
      end
   end

   // Byte phase restarts whenever the read position is moved by software.
   sfs_pkg::sfs_byte_e next_byte_phase;
   always_comb
   begin
      next_byte_phase = byte_phase;
      if (flush || rd_ptr_wr)
      begin
         next_byte_phase = sfs_pkg::BYTE_HI;
      end
      else if (data_rd && have_data)
      begin
         case (byte_phase)
            sfs_pkg::BYTE_HI:  next_byte_phase = sfs_pkg::BYTE_MID;
            sfs_pkg::BYTE_MID: next_byte_phase = sfs_pkg::BYTE_LO;
            sfs_pkg::BYTE_LO:  next_byte_phase = sfs_pkg::BYTE_HI;
            default:           next_byte_phase = sfs_pkg::BYTE_HI;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         byte_phase <= sfs_pkg::BYTE_HI;
      end
      else if (ce)
      begin
         byte_phase <= next_byte_phase;
      end
   end

   // Storage has no reset; count gates reads, but a read pointer write can make old or unwritten words visible.
   always_ff @(posedge core_clk)
   begin
      if (ce && accept && !flush)
      begin
         mem[write_pointer] <= push_word;
      end
   end

   // Configuration writes; the marker bit stays set until its entry is attempted.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         threshold                 <= sfs_pkg::THRESHOLD_RESET;
         status_clear_on_data_read <= sfs_pkg::STAT_CLR_RESET;
         af_type                   <= 1'b0;
         rollover_on_full          <= sfs_pkg::ROLL_RESET;
         mark_pending              <= 1'b0;
         sync_role                 <= 1'b0;
         af_enable                 <= 1'b0;
         drdy_enable               <= 1'b0;
      end
      else if (ce)
      begin
         if (wr_stb && (reg_req.addr == sfs_pkg::THRESHOLD_ADDR))
         begin
            threshold <= reg_req.wdata;
         end
         if (ctrl_wr)
         begin
            status_clear_on_data_read <= reg_req.wdata[sfs_pkg::CTRL_STAT_CLR_BIT];
            af_type                   <= reg_req.wdata[sfs_pkg::CTRL_AF_TYPE_BIT];
            rollover_on_full          <= reg_req.wdata[sfs_pkg::CTRL_ROLL_BIT];
         end
         if (ctrl_wr && reg_req.wdata[sfs_pkg::CTRL_MARK_BIT] && !flush)
         begin
            mark_pending <= 1'b1;
         end
         else if (flush || !sample_valid)
         begin
            mark_pending <= 1'b0;
         end
         if (wr_stb && (reg_req.addr == sfs_pkg::SYSTEM_SETUP_ADDR))
         begin
            sync_role <= reg_req.wdata[sfs_pkg::ROLE_BIT];
         end
         if (wr_stb && (reg_req.addr == sfs_pkg::IRQ_ENABLE_ADDR))
         begin
            af_enable   <= reg_req.wdata[sfs_pkg::EN_AF_BIT];
            drdy_enable <= reg_req.wdata[sfs_pkg::EN_DRDY_BIT];
         end
      end
   end

   // Status flags: a setting event in the clearing cycle wins.
   wire logic [8:0] af_level   = 9'(sfs_pkg::DEPTH) - {1'b0, threshold};
   wire logic       af_cond    = (next_count >= af_level) && !flush;
   wire logic       af_set     = af_type ? (af_cond && af_armed)
                                         : (push_req && af_cond);
   wire logic       flag_clear = stat_rd || (data_rd && status_clear_on_data_read);
   wire logic       next_a_full     = af_set || (a_full && !flag_clear);
   wire logic       next_data_ready = (accept && !flush) || (data_ready && !flag_clear);
   wire logic       next_af_armed   = af_type ? ((af_armed && !af_set) || pop) : 1'b1;
   wire logic       next_af_enable  = (wr_stb && (reg_req.addr == sfs_pkg::IRQ_ENABLE_ADDR))
                                      ? reg_req.wdata[sfs_pkg::EN_AF_BIT] : af_enable;
   wire logic       next_dr_enable  = (wr_stb && (reg_req.addr == sfs_pkg::IRQ_ENABLE_ADDR))
                                      ? reg_req.wdata[sfs_pkg::EN_DRDY_BIT] : drdy_enable;

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         a_full     <= 1'b0;
         data_ready <= 1'b0;
         af_armed   <= 1'b1;
         irq        <= 1'b0;
      end
      else if (ce)
      begin
         a_full     <= next_a_full;
         data_ready <= next_data_ready;
         af_armed   <= next_af_armed;
         irq        <= (next_a_full && next_af_enable)
                       || (next_data_ready && next_dr_enable);
      end
   end

   // Read mux; the timing reset bit is self-clearing and always reads back zero.
   wire logic [DATA_W-1:0] head_word = mem[read_pointer];
   logic [7:0]             data_byte;
   always_comb
   begin
      case (byte_phase)
         sfs_pkg::BYTE_HI:  data_byte = head_word[23:16];
         sfs_pkg::BYTE_MID: data_byte = head_word[15:8];
         sfs_pkg::BYTE_LO:  data_byte = head_word[7:0];
         default:           data_byte = head_word[23:16];
      endcase
      if (!have_data)
      begin
         data_byte = sfs_pkg::DATA_PORT_EMPTY;
      end
   end

   logic [7:0] rd_mux;
   always_comb
   begin
      rd_mux = 8'h00;
      case (reg_req.addr)
         sfs_pkg::STATUS1_ADDR:
         begin
            rd_mux[sfs_pkg::STAT_AF_BIT]   = a_full;
            rd_mux[sfs_pkg::STAT_DRDY_BIT] = data_ready;
         end
         sfs_pkg::WRITE_POINTER_ADDR:  rd_mux = write_pointer;
         sfs_pkg::READ_POINTER_ADDR:   rd_mux = read_pointer;
         sfs_pkg::COUNT_HIGH_ADDR:     rd_mux = {count[8], lost_sample_counter};
         sfs_pkg::COUNT_LOW_ADDR:      rd_mux = count[7:0];
         sfs_pkg::DATA_PORT_ADDR:      rd_mux = data_byte;
         sfs_pkg::THRESHOLD_ADDR:      rd_mux = threshold;
         sfs_pkg::BUFFER_CONTROL_ADDR:
         begin
            rd_mux[sfs_pkg::CTRL_MARK_BIT]     = mark_pending;
            rd_mux[sfs_pkg::CTRL_STAT_CLR_BIT] = status_clear_on_data_read;
            rd_mux[sfs_pkg::CTRL_AF_TYPE_BIT]  = af_type;
            rd_mux[sfs_pkg::CTRL_ROLL_BIT]     = rollover_on_full;
         end
         sfs_pkg::SYSTEM_SETUP_ADDR:   rd_mux[sfs_pkg::ROLE_BIT] = sync_role;
         sfs_pkg::IRQ_ENABLE_ADDR:
         begin
            rd_mux[sfs_pkg::EN_AF_BIT]   = af_enable;
            rd_mux[sfs_pkg::EN_DRDY_BIT] = drdy_enable;
         end
         default:                      rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         reg_rdata <= 8'h00;
      end
      else if (ce && rd_stb)
      begin
         reg_rdata <= rd_mux;
      end
   end

   // Trigger pin synchroniser; only the second stage feeds the edge detector.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         sync_trigger_pin_meta <= 1'b1;
         sync_trigger_pin_sync <= 1'b1;
         sync_trigger_pin_prev <= 1'b1;
      end
      else if (ce)
      begin
         sync_trigger_pin_meta <= sync_trigger_pin_in;
         sync_trigger_pin_sync <= sync_trigger_pin_meta;
         sync_trigger_pin_prev <= sync_trigger_pin_sync;
      end
   end

   // Sync sources: measuring blocks the controller write, targets ignore it.
   wire logic meas_busy   = bandgap_enable || inphase_channel_enable
                            || quadrature_channel_enable;
   wire logic ctrl_sync   = tsr_wr && !meas_busy && sync_role;
   wire logic sync_trigger_pin_edge   = trigger_input_edge ? (sync_trigger_pin_sync && !sync_trigger_pin_prev)
                                               : (!sync_trigger_pin_sync && sync_trigger_pin_prev);
   wire logic target_sync = !sync_role && sync_trigger_pin_edge;
   wire logic div_reset   = ctrl_sync || target_sync;

   // ADC clock divider runs on the PLL rate, here represented by the core clock.
   wire logic [9:0] div_last = adc_div_select ? 10'(sfs_pkg::ADC_DIV_SLOW - 1)
                                              : 10'(sfs_pkg::ADC_DIV_FAST - 1);
   logic [9:0] next_div_cnt;
   always_comb
   begin
      next_div_cnt = div_cnt;
      if (div_reset)
      begin
         next_div_cnt = 10'h000;
      end
      else if (pll_enable)
      begin
         next_div_cnt = (div_cnt >= div_last) ? 10'h000 : div_cnt + 10'h001;
      end
   end

   // Pulse length counter and pin drive per role and drive type.
   wire logic [2:0] next_pulse_cnt = ctrl_sync ? 3'(sfs_pkg::SYNC_PULSE_CYCLES)
                                     : (pulse_cnt != 3'h0) ? pulse_cnt - 3'h1 : 3'h0;
   wire logic       pulse_on       = (next_pulse_cnt != 3'h0);
   wire logic       next_pin_out   = (trigger_output_drive == sfs_pkg::DRIVE_PUSH_HIGH)
                                     ? pulse_on
                                     : (trigger_output_drive == sfs_pkg::DRIVE_PUSH_LOW)
                                     ? !pulse_on : 1'b0;
   wire logic       push_drive     = (trigger_output_drive == sfs_pkg::DRIVE_PUSH_HIGH)
                                     || (trigger_output_drive == sfs_pkg::DRIVE_PUSH_LOW);
   wire logic       next_pin_oe_n  = !(sync_role && (push_drive || pulse_on));

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         div_cnt               <= 10'h000;
         adc_clk               <= 1'b0;
         pulse_cnt             <= 3'h0;
         sync_trigger_pin_out  <= 1'b0;
         sync_trigger_pin_oe_n <= 1'b1;
      end
      else if (ce)
      begin
         div_cnt               <= next_div_cnt;
         adc_clk               <= adc_div_select ? next_div_cnt[9] : next_div_cnt[8];
         pulse_cnt             <= next_pulse_cnt;
         sync_trigger_pin_out  <= next_pin_out;
         sync_trigger_pin_oe_n <= next_pin_oe_n;
      end
   end

   // Checks on the buffer and sync behaviour.
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   chk_wr_ptr_step: assert property (ce && accept && !flush |=>
      write_pointer == 8'($past(write_pointer) + 8'h01)) else $error("write pointer slip");
   chk_rd_ptr_sample: assert property (ce && pop && !flush && !rd_ptr_wr |=>
      read_pointer == 8'($past(read_pointer) + 8'h01) && byte_phase == sfs_pkg::BYTE_HI)
      else $error("read pointer did not step after third byte");
   chk_count_gap: assert property (count[7:0] == 8'(write_pointer - read_pointer))
      else $error("count disagrees with pointers");
   chk_lost_saturate: assert property (ce && lost_sample_counter == sfs_pkg::LOST_MAX
      && !pop && !flush |=> lost_sample_counter == sfs_pkg::LOST_MAX)
      else $error("lost counter wrapped");
   chk_lost_clear: assert property (ce && pop |=> lost_sample_counter == 7'h00)
      else $error("lost counter not cleared by sample read");
   chk_af_level: assert property (ce && !af_type && push_req && af_cond |=> a_full)
      else $error("almost-full flag missed");
   chk_irq_follow: assert property (a_full && af_enable |-> irq)
      else $error("interrupt not driven by almost-full");
   chk_flush_zero: assert property (ce && flush |=> write_pointer == 8'h00
      && read_pointer == 8'h00 && count == 9'h000 && lost_sample_counter == 7'h00)
      else $error("flush left state behind");
   chk_stop_full: assert property (ce && full && !rollover_on_full && push_req
      && !pop && !flush && !rd_ptr_wr |=> $stable(write_pointer) && $stable(read_pointer))
      else $error("pointers moved in stop mode");
   chk_sync_pulse: assert property (ce && ctrl_sync |=>
      pulse_cnt == 3'(sfs_pkg::SYNC_PULSE_CYCLES) && !sync_trigger_pin_oe_n)
      else $error("sync pulse not started");

   cov_rollover: cover property (ce && overwrite);
   cov_target_sync: cover property (ce && target_sync);
   cov_sample_read: cover property (ce && pop ##1 ce && data_rd);

endmodule : sfs_sample_fifo_sync

// >>> tb/sfs_host.sv
// Host processor model issuing single-byte register accesses.
`timescale 1ns/100ps
module sfs_host (
   input  wire logic             core_clk,
   output sfs_pkg::sfs_reg_req_s reg_req
);
   initial reg_req = '0;
   // One access per call, raised after an edge and held across the taking edge.
   // Buffered data is drained only by repeated reads of the fixed data port.
   // Read pointer written only with the PLL up; sync with enables low.
   task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
      @(posedge core_clk);
      #1;
      reg_req = '{addr: a, wr: w, rd: !w, wdata: d};
      @(posedge core_clk);
      #1;
      reg_req = '0;
   endtask : acc
endmodule : sfs_host

// >>> tb/sfs_sample_fifo_sync_bench.sv
// Self-checking bench for the sample buffer and timing sync block.
`timescale 1ns/100ps
module sfs_sample_fifo_sync_bench;
   logic                  core_clk = 0, rst = 1, sv = 0, pll = 1, meas = 0, po, oe_n, irq, ac;
   logic                  dsel = 0, ext = 1, en = 1;
   logic [23:0]           sd = '0;
   logic [23:0]           s[3];
   logic [7:0]            rdat, q[$];
   logic [31:0]           lfsr = 32'hD8468698;
   logic                  pend = 0;
   int                    error_cnt = 0, compares = 0, n, m, lo = 0;
   sfs_pkg::sfs_reg_req_s req;
   wire                   pin = oe_n ? ext : po; // A far device or the pull-up sets the idle level.
   always #10 core_clk = ~core_clk;
   sfs_host HOST (.core_clk(core_clk), .reg_req(req));
   sfs_sample_fifo_sync DUT (.core_clk(core_clk), .rst(rst), .ce(en), .reg_req(req),
      .reg_rdata(rdat), .sample_valid(sv), .sample_data(sd), .pll_enable(pll),
      .adc_div_select(dsel), .bandgap_enable(meas), .inphase_channel_enable(meas),
      .quadrature_channel_enable(meas), .trigger_input_edge(!dsel),
      .trigger_output_drive({1'b0, pll}), .sync_trigger_pin_in(pin),
      .sync_trigger_pin_out(po), .sync_trigger_pin_oe_n(oe_n), .irq(irq), .adc_clk(ac));
   // Random stimulus source.
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next
   task automatic check(input logic [15:0] seen, exp);
      compares++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic rd(input logic [7:0] a, exp);
      q.push_back(exp);
      HOST.acc(a, 0, 0);
   endtask : rd
   task automatic wr(input logic [7:0] a, d);
      HOST.acc(a, 1, d);
   endtask : wr
   // The first sample of each call is kept in s[1] as the expected head.
   task automatic push(input int k);
      for (int i = 0; i < k; i++)
      begin
         @(posedge core_clk);
         #1;
         lfsr = lfsr_next(lfsr);
         sv = 1;
         sd = lfsr[23:0];
         if (i == 0)
            s[1] = sd;
      end
      @(posedge core_clk);
      #1;
      sv = 0;
   endtask : push
   task automatic summarize;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : summarize
   // Read data lands one cycle after the taking edge; sync pulse length is tallied too.
   always @(posedge core_clk)
   begin
      if (pend)
         check(rdat, q.pop_front());
      pend <= req.rd;
      lo <= lo + (!oe_n && po);
   end
   // A hang ends the run as a failure.
   initial
   begin
      #200000;
      error_cnt++;
      summarize();
   end
   initial
   begin
      repeat (10) @(posedge core_clk);
      #1;
      rst = 0;
      rd(8'h0D, 8'h7F);
      rd(8'h0E, 8'h0A);
      rd(8'h0C, 8'hFF);
      rd(8'h05, 8'h00);
      for (n = 0; n < 3; n++)
      begin
         push(1);
         s[n] = sd;
      end
      rd(8'h00, 8'h20);
      rd(8'h08, 8'h03);
      en = 0;
      push(1);
      en = 1;
      rd(8'h08, 8'h03);
      for (n = 0; n < 3; n++)
         rd(8'h0C, s[0][23-8*n -: 8]);
      rd(8'h09, 8'h01);
      rd(8'h0B, 8'h02);
      wr(8'h09, 8'h00);
      rd(8'h0B, 8'h03);
      pll = 0;
      wr(8'h09, 8'h02);
      rd(8'h09, 8'h00);
      pll = 1;
      wr(8'h0E, 8'h18);
      rd(8'h0E, 8'h08);
      rd(8'h08, 8'h00);
      wr(8'h0E, 8'h28);
      for (n = 0; n < 3; n++)
         rd(8'h0C, sfs_pkg::MARKER_TAG[23-8*n -: 8]);
      wr(8'h0D, 8'h00);
      wr(8'h80, 8'h80);
      push(258);
      check({7'h0, irq}, 8'h01);
      rd(8'h0A, 8'h82);
      rd(8'h08, 8'h01);
      rd(8'h00, 8'hA0);
      check({7'h0, irq}, 8'h00);
      for (n = 0; n < 3; n++)
         rd(8'h0C, s[1][23-8*n -: 8]);
      rd(8'h0A, 8'h00);
      rd(8'h0B, 8'hFF);
      wr(8'h0E, 8'h0A);
      push(2);
      rd(8'h09, 8'h03);
      rd(8'h0A, 8'h81);
      meas = 1;
      wr(8'h11, 8'h80);
      wr(8'h10, 8'h80);
      repeat (8) @(posedge core_clk);
      #1;
      check(8'(lo), 8'h00);
      meas = 0;
      wr(8'h10, 8'h80);
      repeat (10) @(posedge core_clk);
      check(8'(lo), 8'(sfs_pkg::SYNC_PULSE_CYCLES));
      // Target role: an edge on the pin restarts the divider at a known phase.
      ext = 0;
      wr(8'h11, 8'h00);
      for (m = 0; m < 2; m++)
      begin
         dsel = m[0];
         ext = m[0];
         repeat (4) @(posedge core_clk);
         #1;
         ext = !m[0];
         repeat (3) @(posedge core_clk);
         #1;
         check({15'h0, ac}, 16'h0000);
         n = 0;
         while (!ac && n < 2000)
         begin
            @(posedge core_clk);
            #1;
            n++;
         end
         check(16'(n), 16'((m ? sfs_pkg::ADC_DIV_SLOW : sfs_pkg::ADC_DIV_FAST) / 2));
      end
      summarize();
   end
endmodule : sfs_sample_fifo_sync_bench
